// >>> stoi_pkg.sv
package stoi_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_RELAY     = 8'h04;
	localparam logic [7:0] ADDR_BRAKE     = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0c;
	localparam logic [7:0] ADDR_TRIP      = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;

	// control fields
	localparam int CTRL_START_SRC_LSB  = 0;   // start_source_select, 2 bits
	localparam int CTRL_BRAKE_SEL_LSB  = 4;   // stop_mode_brake_select, 2 bits
	localparam int CTRL_EXT_MENU_LSB   = 8;   // extended_menu_access, 8 bits
	localparam int CTRL_FAULT_RST_BIT  = 31;  // write-one pulse, reads zero
	localparam int BRAKE_EN_BIT        = 1;   // brake select bit enabling transistor

	// relay fields
	localparam int RELAY1_SEL_LSB      = 0;   // relay1_function_select, 8 bits
	localparam int RELAY2_SEL_LSB      = 8;   // relay2_function_select, 8 bits

	// brake fields
	localparam int BRAKE_RES_LSB       = 0;   // brake_resistance_value, 16 bits
	localparam int BRAKE_PWR_LSB       = 16;  // brake_resistor_power, 16 bits

	// reset values
	localparam logic [1:0]  RST_START_SRC  = 2'h0;
	localparam logic [1:0]  RST_BRAKE_SEL  = 2'h0;
	localparam logic [7:0]  RST_EXT_MENU   = 8'h00;
	localparam logic [7:0]  RST_RELAY_SEL  = 8'h00;
	localparam logic [15:0] RST_BRAKE_RES  = 16'h0000;
	localparam logic [15:0] RST_BRAKE_PWR  = 16'h0000;
	localparam logic [2:0]  RST_IRQ_MASK   = 3'h0;

	// codes and magic values
	localparam logic [7:0] RELAY_FN_STO    = 8'h0d;  // 13
	localparam logic [7:0] EXT_MENU_BRAKE  = 8'hc9;  // 201
	localparam logic [7:0] TRIP_STO_FAULT  = 8'h1d;  // 29
	localparam logic [1:0] SRC_TERMINAL    = 2'h0;
	localparam logic [1:0] SRC_KEYPAD      = 2'h1;
	localparam logic [1:0] SRC_FIELDBUS    = 2'h2;
	localparam logic [1:0] DISP_NORMAL     = 2'h0;
	localparam logic [1:0] DISP_INHIBIT    = 2'h1;
	localparam logic [1:0] DISP_TRIP       = 2'h2;

	// interrupt bits
	localparam int IRQ_STO_ON   = 0;
	localparam int IRQ_FAULT    = 1;
	localparam int IRQ_STO_OFF  = 2;

	// timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int DISC_TIME_US    = 5000;
	localparam int DISC_CYCLES     = DISC_TIME_US * 1000 / CLK_PERIOD_NS;

	typedef enum logic [1:0] {ST_STANDBY, ST_RUN, ST_STO} stoi_state_t;
endpackage : stoi_pkg

// >>> stoi_sync.sv
`timescale 1ns/1ns
module stoi_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// two flops per bit; meta is read by nothing else
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				meta[i]     <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta[i]     <= async_in[i];
				sync_out[i] <= meta[i];
			end
		end
	end
endmodule : stoi_sync

// >>> stoi_top.sv
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module stoi_top #(
	parameter int DISC_CYCLES = stoi_pkg::DISC_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sto_ch_a_pin,
	input  wire logic        sto_ch_b_pin,
	input  wire logic        fault_reset_pin,
	input  wire logic        start_term_pin,
	input  wire logic        start_keypad,
	input  wire logic        start_fieldbus,
	input  wire logic        drive_trip,
	input  wire logic [7:0]  drive_trip_code,
	input  wire logic        relay1_request,
	input  wire logic        relay2_request,
	input  wire logic        brake_request,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             torque_enable,
	output logic             drive_running,
	output logic             sto_active,
	output logic             sto_status,
	output logic      [1:0]  disp_sel,
	output logic      [7:0]  disp_code,
	output logic             relay1_closed,
	output logic             relay2_closed,
	output logic             brake_switch,
	output logic             brake_ovl_en,
	output logic      [15:0] brake_res_ohm,
	output logic      [15:0] brake_pwr,
	output logic             healthy,
	output logic             irq
);
	logic [3:0]  pins_sync;
	logic        ch_a;
	logic        ch_b;
	logic        fault_rst_lvl;
	logic        start_term;
	logic        fault_rst_prev;
	stoi_pkg::stoi_state_t state;
	stoi_pkg::stoi_state_t next_state;
	logic [1:0]  start_src;
	logic [1:0]  brake_sel;
	logic [7:0]  ext_menu;
	logic [7:0]  relay1_sel;
	logic [7:0]  relay2_sel;
	logic [2:0]  irq_stat;
	logic [2:0]  irq_mask;
	logic        chan_fault;
	logic [19:0] disc_cnt;

	stoi_sync #(
		.W(4)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({start_term_pin, fault_reset_pin, sto_ch_b_pin, sto_ch_a_pin}),
		.sync_out (pins_sync)
	);
	assign ch_a          = pins_sync[0];
	assign ch_b          = pins_sync[1];
	assign fault_rst_lvl = pins_sync[2];
	assign start_term    = pins_sync[3];

	// decode
	wire energised  = ch_a & ch_b;
	wire disagree   = ch_a ^ ch_b;
	wire wr_ctrl    = reg_wr && (reg_addr == stoi_pkg::ADDR_CTRL);
	wire wr_relay   = reg_wr && (reg_addr == stoi_pkg::ADDR_RELAY);
	wire wr_brake   = reg_wr && (reg_addr == stoi_pkg::ADDR_BRAKE);
	wire wr_istat   = reg_wr && (reg_addr == stoi_pkg::ADDR_IRQ_STAT);
	wire wr_imask   = reg_wr && (reg_addr == stoi_pkg::ADDR_IRQ_MASK);
	wire sw_rst     = wr_ctrl && reg_wdata[stoi_pkg::CTRL_FAULT_RST_BIT];
	wire fault_clr  = sw_rst | (fault_rst_lvl & ~fault_rst_prev);
	wire ext_ok     = (ext_menu == stoi_pkg::EXT_MENU_BRAKE);
	wire disc_done  = disagree && (disc_cnt >= 20'(DISC_CYCLES - 1));
	wire start_cmd  = (start_src == stoi_pkg::SRC_TERMINAL) ? start_term :
	                  (start_src == stoi_pkg::SRC_KEYPAD)   ? start_keypad :
	                  (start_src == stoi_pkg::SRC_FIELDBUS) ? start_fieldbus : 1'b0;
	wire tripped    = chan_fault | drive_trip;
	// no register bit reaches this term: torque-off cannot be masked
	wire off_req    = ~energised;
	wire sto_enter  = (state != stoi_pkg::ST_STO) && off_req;
	wire sto_leave  = (state == stoi_pkg::ST_STO) && (next_state != stoi_pkg::ST_STO);
	wire [2:0] ev   = {sto_leave, disc_done & ~chan_fault, sto_enter};
	wire [31:0] ctrl_rd  = {16'h0, ext_menu, 2'h0, brake_sel, 2'h0, start_src};
	wire [31:0] stat_rd  = {24'h0, healthy, chan_fault, sto_active, ch_b, ch_a,
	                        drive_running, 2'(state)};
	wire [31:0] rd_mux   =
		(reg_addr == stoi_pkg::ADDR_CTRL)     ? ctrl_rd :
		(reg_addr == stoi_pkg::ADDR_RELAY)    ? {16'h0, relay2_sel, relay1_sel} :
		(reg_addr == stoi_pkg::ADDR_BRAKE)    ? {brake_pwr, brake_res_ohm} :
		(reg_addr == stoi_pkg::ADDR_STATUS)   ? stat_rd :
		(reg_addr == stoi_pkg::ADDR_TRIP)     ? {24'h0, disp_code} :
		(reg_addr == stoi_pkg::ADDR_IRQ_STAT) ? {29'h0, irq_stat} :
		(reg_addr == stoi_pkg::ADDR_IRQ_MASK) ? {29'h0, irq_mask} : 32'h0;
	// display priority: trip code beats inhibit
	wire [1:0] next_disp_sel = tripped ? stoi_pkg::DISP_TRIP :
	                           (next_state == stoi_pkg::ST_STO) ? stoi_pkg::DISP_INHIBIT :
	                           stoi_pkg::DISP_NORMAL;
	wire [7:0] next_disp_code = chan_fault ? stoi_pkg::TRIP_STO_FAULT :
	                            drive_trip ? drive_trip_code : 8'h00;

	// state machine
	always_comb begin
		next_state = state;
		case (state)
			stoi_pkg::ST_STANDBY: begin
				if (off_req)
					next_state = stoi_pkg::ST_STO;
				else if (start_cmd && !tripped)
					next_state = stoi_pkg::ST_RUN;
			end
			stoi_pkg::ST_RUN: begin
				if (off_req)
					next_state = stoi_pkg::ST_STO;
				else if (!start_cmd || tripped)
					next_state = stoi_pkg::ST_STANDBY;
			end
			stoi_pkg::ST_STO: begin
				// starts ignored here; only a clean input and no faults release
				if (energised && !tripped)
					next_state = stoi_pkg::ST_STANDBY;
			end
			default: next_state = stoi_pkg::ST_STO;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state <= stoi_pkg::ST_STO;
		else
			state <= next_state;
	end

	// channel discrepancy watchdog
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			disc_cnt       <= 20'h00000;
			chan_fault     <= 1'b0;
			fault_rst_prev <= 1'b0;
		end else begin
			fault_rst_prev <= fault_rst_lvl;
			disc_cnt       <= disagree ? (disc_done ? disc_cnt : disc_cnt + 20'h00001) : 20'h00000;
			// set wins over a reset in the same cycle
			if (disc_done)
				chan_fault <= 1'b1;
			else if (fault_clr)
				chan_fault <= 1'b0;
		end
	end

	// registered outputs; one cycle after the synchronised input
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			torque_enable <= 1'b0;
			drive_running <= 1'b0;
			sto_active    <= 1'b1;
			sto_status    <= 1'b1;
			disp_sel      <= stoi_pkg::DISP_INHIBIT;
			disp_code     <= 8'h00;
			relay1_closed <= 1'b0;
			relay2_closed <= 1'b0;
			brake_switch  <= 1'b0;
			brake_ovl_en  <= 1'b0;
			healthy       <= 1'b0;
			irq           <= 1'b0;
		end else begin
			torque_enable <= (next_state == stoi_pkg::ST_RUN) && energised;
			drive_running <= (next_state == stoi_pkg::ST_RUN);
			sto_active    <= (next_state == stoi_pkg::ST_STO);
			sto_status    <= off_req;
			disp_sel      <= next_disp_sel;
			disp_code     <= next_disp_code;
			relay1_closed <= relay1_request &&
				!((relay1_sel == stoi_pkg::RELAY_FN_STO) && (next_state == stoi_pkg::ST_STO));
			relay2_closed <= relay2_request &&
				!((relay2_sel == stoi_pkg::RELAY_FN_STO) && (next_state == stoi_pkg::ST_STO));
			brake_switch  <= brake_sel[stoi_pkg::BRAKE_EN_BIT] && brake_request;
			brake_ovl_en  <= ext_ok;
			healthy       <= !tripped;
			irq           <= |(irq_stat & irq_mask);
		end
	end

	// configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_src  <= stoi_pkg::RST_START_SRC;
			brake_sel  <= stoi_pkg::RST_BRAKE_SEL;
			ext_menu   <= stoi_pkg::RST_EXT_MENU;
			relay1_sel <= stoi_pkg::RST_RELAY_SEL;
			relay2_sel <= stoi_pkg::RST_RELAY_SEL;
			irq_mask   <= stoi_pkg::RST_IRQ_MASK;
		end else begin
			if (wr_ctrl) begin
				start_src <= reg_wdata[stoi_pkg::CTRL_START_SRC_LSB +: 2];
				brake_sel <= reg_wdata[stoi_pkg::CTRL_BRAKE_SEL_LSB +: 2];
				ext_menu  <= reg_wdata[stoi_pkg::CTRL_EXT_MENU_LSB +: 8];
			end
			if (wr_relay) begin
				relay1_sel <= reg_wdata[stoi_pkg::RELAY1_SEL_LSB +: 8];
				relay2_sel <= reg_wdata[stoi_pkg::RELAY2_SEL_LSB +: 8];
			end
			if (wr_imask)
				irq_mask <= reg_wdata[2:0];
		end
	end

	// brake overload settings are locked unless the extended menu is open
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			brake_res_ohm <= stoi_pkg::RST_BRAKE_RES;
			brake_pwr     <= stoi_pkg::RST_BRAKE_PWR;
		end else if (wr_brake && ext_ok) begin
			brake_res_ohm <= reg_wdata[stoi_pkg::BRAKE_RES_LSB +: 16];
			brake_pwr     <= reg_wdata[stoi_pkg::BRAKE_PWR_LSB +: 16];
		end
	end

	// sticky events, write one to clear, set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			irq_stat <= 3'h0;
		else
			irq_stat <= (irq_stat & ~(wr_istat ? reg_wdata[2:0] : 3'h0)) | ev;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			reg_rdata <= 32'h0;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_off_fast;
		!energised |=> !torque_enable && sto_active;
	endproperty
	a_off_fast: assert property (p_off_fast) else $error("torque not removed");

	property p_pin_to_torque;
		$fell(sto_ch_a_pin) ##1 !sto_ch_a_pin [*3] |=> !torque_enable;
	endproperty
	a_pin_to_torque: assert property (p_pin_to_torque) else $error("slow torque off");

	property p_status;
		!energised |-> ##1 sto_status;
	endproperty
	a_status: assert property (p_status) else $error("status not updated");

	property p_fault_report;
		// code and flag follow the latched fault, so two edges after detection
		disc_done |-> ##2 (disp_code == stoi_pkg::TRIP_STO_FAULT) && !healthy;
	endproperty
	a_fault_report: assert property (p_fault_report) else $error("fault not shown");

	property p_fault_trip;
		chan_fault |-> ##1 (disp_sel == stoi_pkg::DISP_TRIP);
	endproperty
	a_fault_trip: assert property (p_fault_trip) else $error("no fault 29 trip");

	property p_inhibit_disp;
		(state == stoi_pkg::ST_STO) && !tripped && !energised |=>
			disp_sel == stoi_pkg::DISP_INHIBIT;
	endproperty
	a_inhibit_disp: assert property (p_inhibit_disp) else $error("inhibit not shown");

	property p_ignore_start;
		(state == stoi_pkg::ST_STO) && !energised |=> state == stoi_pkg::ST_STO;
	endproperty
	a_ignore_start: assert property (p_ignore_start) else $error("left mode unpowered");

	property p_leave;
		(state == stoi_pkg::ST_STO) && $past(state == stoi_pkg::ST_STO) ##1
			state != stoi_pkg::ST_STO |-> $past(energised) && !$past(tripped);
	endproperty
	a_leave: assert property (p_leave) else $error("left mode too early");

	property p_relay1;
		(relay1_sel == stoi_pkg::RELAY_FN_STO) && (next_state == stoi_pkg::ST_STO) |=>
			!relay1_closed;
	endproperty
	a_relay1: assert property (p_relay1) else $error("relay 1 closed");

	property p_relay2;
		(relay2_sel == stoi_pkg::RELAY_FN_STO) && (next_state == stoi_pkg::ST_STO) |=>
			!relay2_closed;
	endproperty
	a_relay2: assert property (p_relay2) else $error("relay 2 closed");

	property p_start;
		(state == stoi_pkg::ST_STANDBY) && energised && start_cmd && !tripped |=>
			state == stoi_pkg::ST_RUN ##0 torque_enable;
	endproperty
	a_start: assert property (p_start) else $error("start not obeyed");

	property p_brake_lock;
		wr_brake && !ext_ok |=> $stable(brake_res_ohm) && $stable(brake_pwr);
	endproperty
	a_brake_lock: assert property (p_brake_lock) else $error("brake setup not locked");

	property p_healthy;
		tripped |=> !healthy;
	endproperty
	a_healthy: assert property (p_healthy) else $error("healthy while tripped");

	property p_brake_off;
		!brake_sel[stoi_pkg::BRAKE_EN_BIT] |=> !brake_switch;
	endproperty
	a_brake_off: assert property (p_brake_off) else $error("brake on while disabled");

	property p_no_run;
		!energised |=> !drive_running;
	endproperty
	a_no_run: assert property (p_no_run) else $error("running while unpowered");

	c_sto_enter: cover property (state == stoi_pkg::ST_RUN ##1 state == stoi_pkg::ST_STO);
	c_fault:     cover property (disc_done ##[1:20] fault_clr);
	c_restart:   cover property (state == stoi_pkg::ST_STO ##1 state == stoi_pkg::ST_STANDBY
		##[1:5] state == stoi_pkg::ST_RUN);
endmodule : stoi_top

// >>> stoi_src_model.sv
`timescale 1ns/1ns
// safety relay with two independent contacts; an open contact leaves the
// input on its pull-down, so a released channel reads low, never the last value
module stoi_src_model #(
	parameter int SW_DLY = 2
) (
	input  wire logic       clk,
	input  wire logic [1:0] contact_closed,
	output logic            ch_a,
	output logic            ch_b
);
	logic [1:0] dly_q [0:7];

	// contacts take SW_DLY cycles to move, like a slow relay
	always @(posedge clk) begin
		dly_q[0] <= contact_closed;
		for (int k = 1; k < 8; k++) begin
			dly_q[k] <= dly_q[k-1];
		end
	end

	// closed contact applies the 24 V level, open removes it
	assign ch_a = (SW_DLY == 0) ? contact_closed[0] : (dly_q[SW_DLY-1][0] === 1'b1);
	assign ch_b = (SW_DLY == 0) ? contact_closed[1] : (dly_q[SW_DLY-1][1] === 1'b1);
endmodule : stoi_src_model

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        clk, rst, fault_reset_pin, start_term_pin, start_keypad, start_fieldbus;
	logic        drive_trip, relay1_request, relay2_request, brake_request, reg_wr, reg_rd;
	logic [7:0]  drive_trip_code, reg_addr, disp_code;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [1:0]  contact_closed, disp_sel;
	logic        sto_ch_a_pin, sto_ch_b_pin, torque_enable, drive_running, sto_active;
	logic        sto_status, relay1_closed, relay2_closed, brake_switch, brake_ovl_en;
	logic        healthy, irq;
	logic [15:0] brake_res_ohm, brake_pwr;
	int          num_errors, n_tests, i;

	stoi_src_model #(.SW_DLY(2)) u_stoi_src_model (.clk(clk), .contact_closed(contact_closed),
		.ch_a(sto_ch_a_pin), .ch_b(sto_ch_b_pin));

	// short discrepancy window keeps the channel fault case quick
	stoi_top #(.DISC_CYCLES(8)) u_stoi_top (.clk(clk), .rst(rst), .sto_ch_a_pin(sto_ch_a_pin),
		.sto_ch_b_pin(sto_ch_b_pin), .fault_reset_pin(fault_reset_pin),
		.start_term_pin(start_term_pin), .start_keypad(start_keypad),
		.start_fieldbus(start_fieldbus), .drive_trip(drive_trip),
		.drive_trip_code(drive_trip_code), .relay1_request(relay1_request),
		.relay2_request(relay2_request), .brake_request(brake_request), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.torque_enable(torque_enable), .drive_running(drive_running), .sto_active(sto_active),
		.sto_status(sto_status), .disp_sel(disp_sel), .disp_code(disp_code),
		.relay1_closed(relay1_closed), .relay2_closed(relay2_closed),
		.brake_switch(brake_switch), .brake_ovl_en(brake_ovl_en),
		.brake_res_ohm(brake_res_ohm), .brake_pwr(brake_pwr), .healthy(healthy), .irq(irq));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// a wait that ran out of cycles ends the run
	task automatic bound(input int cnt, input int lim);
		if (cnt >= lim) begin
			num_errors++;
			$display("[ERR] wait expected done seen timeout");
			end_of_test;
		end
	endtask : bound

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic reg_write(input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= wd;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : reg_write

	// read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [31:0] rd);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		rd = reg_rdata;
	endtask : reg_read

	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		$display("[ERR] run expected done seen timeout");
		end_of_test;
	end

	initial begin
		{fault_reset_pin, start_term_pin, start_keypad, start_fieldbus, drive_trip} = 5'h00;
		{relay1_request, relay2_request, reg_wr, reg_rd} = 4'h0;
		brake_request   = 1'b1;
		drive_trip_code = 8'h00;
		reg_addr        = 8'h00;
		reg_wdata       = 32'h0000_0000;
		contact_closed  = 2'h0;
		num_errors      = 0;
		n_tests         = 0;
		rst             = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
		chk("sto_active", 1'b1, sto_active);
		chk("torque_enable", 1'b0, torque_enable);
		for (int k = 0; k < 5; k++) begin
			reg_read(k == 4 ? 8'hfc : 8'(k * 4 + (k == 3 ? 12 : 0)), d);
			chk("reset_reg", 32'h0, d);
		end
		reg_write(stoi_pkg::ADDR_IRQ_MASK, 32'h7);
		contact_closed <= 2'h3;
		for (i = 0; i < 20 && sto_active !== 1'b0; i++) cyc(1);
		bound(i, 20);
		chk("sto_status", 1'b0, sto_status);
		reg_read(stoi_pkg::ADDR_IRQ_STAT, d);
		chk("irq_leave", 32'h4, d & 32'h4);
		reg_write(stoi_pkg::ADDR_IRQ_STAT, 32'h7);
		cyc(3);
		chk("irq_clr", 1'b0, irq);
		reg_write(stoi_pkg::ADDR_CTRL, 32'h20);
		cyc(3);
		chk("brake_on", 1'b1, brake_switch);
		reg_write(stoi_pkg::ADDR_CTRL, 32'h0);
		cyc(3);
		chk("brake_off", 1'b0, brake_switch);
		reg_write(stoi_pkg::ADDR_BRAKE, 32'h0064_01f4);
		reg_read(stoi_pkg::ADDR_BRAKE, d);
		chk("brake_locked", 32'h0, d);
		reg_write(stoi_pkg::ADDR_CTRL, 32'h0000_c901);
		reg_write(stoi_pkg::ADDR_BRAKE, 32'h0064_01f4);
		reg_read(stoi_pkg::ADDR_BRAKE, d);
		chk("brake_reg", 32'h0064_01f4, d);
		chk("brake_ovl_en", 1'b1, brake_ovl_en);
		chk("brake_res_ohm", 16'h01f4, brake_res_ohm);
		chk("brake_pwr", 16'h0064, brake_pwr);
		// keypad chosen: a terminal start alone must not run
		start_term_pin <= 1'b1;
		cyc(6);
		chk("run_wrong_src", 1'b0, drive_running);
		start_keypad <= 1'b1;
		for (i = 0; i < 10 && drive_running !== 1'b1; i++) cyc(1);
		bound(i, 10);
		chk("torque_run", 1'b1, torque_enable);
		reg_write(stoi_pkg::ADDR_RELAY, 32'h0000_0d0d);
		{relay1_request, relay2_request} <= 2'h3;
		cyc(3);
		chk("relay1_run", 1'b1, relay1_closed);
		chk("relay2_run", 1'b1, relay2_closed);
		// only channel b opens: one channel is enough to stop
		contact_closed <= 2'h1;
		for (i = 0; i < 8 && torque_enable !== 1'b0; i++) cyc(1);
		bound(i, 8);
		chk("sto_status", 1'b1, sto_status);
		chk("sto_active", 1'b1, sto_active);
		chk("running", 1'b0, drive_running);
		chk("disp_inhibit", stoi_pkg::DISP_INHIBIT, disp_sel);
		chk("relay1_sto", 1'b0, relay1_closed);
		chk("relay2_sto", 1'b0, relay2_closed);
		// irq lags the sticky bit by one cycle
		cyc(1);
		chk("irq_enter", 1'b1, irq);
		reg_write(stoi_pkg::ADDR_IRQ_MASK, 32'h0);
		cyc(2);
		chk("irq_masked", 1'b0, irq);
		reg_write(stoi_pkg::ADDR_IRQ_MASK, 32'h7);
		for (i = 0; i < 40 && disp_code !== stoi_pkg::TRIP_STO_FAULT; i++) cyc(1);
		bound(i, 40);
		chk("disp_trip", stoi_pkg::DISP_TRIP, disp_sel);
		chk("healthy", 1'b0, healthy);
		reg_read(stoi_pkg::ADDR_TRIP, d);
		chk("trip_reg", 32'h1d, d);
		reg_read(stoi_pkg::ADDR_STATUS, d);
		chk("status", 32'h22, d & 32'h23);
		// fault still pending: energised input alone must not release
		contact_closed <= 2'h3;
		cyc(10);
		chk("held_by_fault", 1'b1, sto_active);
		chk("start_ignored", 1'b0, drive_running);
		reg_write(stoi_pkg::ADDR_CTRL, 32'h8000_c901);
		for (i = 0; i < 20 && drive_running !== 1'b1; i++) cyc(1);
		bound(i, 20);
		chk("released", 1'b0, sto_active);
		chk("healthy_back", 1'b1, healthy);
		// control and relay settings at their extremes must not defeat the stop
		reg_write(stoi_pkg::ADDR_CTRL, 32'h0000_ff33);
		reg_write(stoi_pkg::ADDR_RELAY, 32'h0000_ffff);
		contact_closed <= 2'h0;
		drive_trip      <= 1'b1;
		drive_trip_code <= 8'h21;
		cyc(10);
		chk("torque_forced", 1'b0, torque_enable);
		chk("disp_ext_trip", stoi_pkg::DISP_TRIP, disp_sel);
		chk("code_ext_trip", 8'h21, disp_code);
		drive_trip <= 1'b0;
		cyc(3);
		chk("disp_back", stoi_pkg::DISP_INHIBIT, disp_sel);
		// fieldbus start, then a channel fault cleared from the reset pin
		reg_write(stoi_pkg::ADDR_CTRL, 32'h0000_0002);
		start_fieldbus <= 1'b1;
		contact_closed <= 2'h3;
		for (i = 0; i < 20 && drive_running !== 1'b1; i++) cyc(1);
		bound(i, 20);
		contact_closed <= 2'h2;
		for (i = 0; i < 40 && healthy !== 1'b0; i++) cyc(1);
		bound(i, 40);
		chk("code_pin_fault", stoi_pkg::TRIP_STO_FAULT, disp_code);
		// pin edge only after the channels agree, else the set wins
		contact_closed <= 2'h3;
		cyc(6);
		fault_reset_pin <= 1'b1;
		for (i = 0; i < 20 && drive_running !== 1'b1; i++) cyc(1);
		bound(i, 20);
		chk("healthy_pin", 1'b1, healthy);
		end_of_test;
	end
endmodule : tb_top
